// ### dv/ssc_bus_master.sv
`timescale 1ns/1ps

module ssc_bus_master
    import ssc_pkg::*;
(
    input wire logic clk,
    output ssc_ctrl_s ctrl,
    output logic output_enable_n,
    output ssc_addr_t addr,
    output ssc_word_t wdata
);
    logic oe_req = 1'b0;

    initial begin
        ctrl = SSC_CTRL_IDLE;
        output_enable_n = 1'b0;
        addr = SSC_ADDR_RESET;
        wdata = SSC_WORD_RESET;
    end

    // One bus cycle; returns the enable level held over the previous edge
    task automatic cycle(input ssc_ctrl_s c, input ssc_addr_t a, input ssc_word_t d,
                         output logic oe_prev);
        logic wr;
        wr = !(c.low_byte_write_n && c.high_byte_write_n);
        @(negedge clk);
        oe_prev = output_enable_n;
        ctrl <= c;
        addr <= a;
        output_enable_n <= wr ? 1'b1 : oe_req;
        // Undriven bus shows a changing pattern, never a stale word
        wdata <= wr ? d : ~wdata;
        @(posedge clk);
    endtask
endmodule

// ### dv/ssc_sram_ctrl_chk.sv
`timescale 1ns/1ps

module ssc_sram_ctrl_chk
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_sel_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic output_enable_n,
    input wire logic data_io_oe,
    input wire logic low_parity_io_oe,
    input wire logic high_parity_io_oe,
    input wire logic power_down
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic strobe;
    logic wr;
    assign strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    assign wr = !(low_byte_write_n && high_byte_write_n);

    a_desel_quiet: assert property (chip_sel_n && strobe |=> ##1 !data_io_oe)
        else $error("data driven after deselect");
    a_desel_power: assert property (chip_sel_n && strobe |-> ##[1:2] power_down)
        else $error("no power down after deselect");
    a_oe_gate: assert property (data_io_oe |-> !$past(output_enable_n, 3))
        else $error("data driven while output enable high");
    a_wr_begin_quiet: assert property (!chip_sel_n && proc_addr_strobe_n
        && !ctrl_addr_strobe_n && wr |=> ##1 !data_io_oe)
        else $error("data driven in write begin");
    a_cont_wr_quiet: assert property (!strobe && wr |=> ##1 !data_io_oe)
        else $error("data driven in burst write");
    // Synchroniser must hold a post-reset sample before the read counts
    a_proc_rd_drive: assert property (!chip_sel_n && !proc_addr_strobe_n
        && !$past(output_enable_n) && !$past(reset) && !$past(reset, 2) |=> ##1 data_io_oe)
        else $error("processor read not driven");
    a_lane_oe_match: assert property (low_parity_io_oe == data_io_oe
        && high_parity_io_oe == data_io_oe)
        else $error("parity enables differ from data enable");
    a_powerup_hiz: assert property ($past(reset) |-> !data_io_oe && power_down)
        else $error("outputs not quiet after power up");

    c_write: cover property (!chip_sel_n && !ctrl_addr_strobe_n && wr);
    c_drive: cover property (data_io_oe);
    c_desel: cover property (power_down && $past(!power_down));
endmodule

bind ssc_sram_ctrl ssc_sram_ctrl_chk chk (.clk, .reset, .chip_sel_n, .proc_addr_strobe_n,
    .ctrl_addr_strobe_n, .low_byte_write_n, .high_byte_write_n, .output_enable_n,
    .data_io_oe, .low_parity_io_oe, .high_parity_io_oe, .power_down);

// ### dv/testbench.sv
`timescale 1ns/1ps

module testbench;
    import ssc_pkg::*;

    typedef struct {int due; logic oe; ssc_word_t w;} ssc_tb_exp_s;
    localparam ssc_ctrl_s C_IDLE = 6'h37;
    localparam ssc_ctrl_s C_PRD = 6'h0F;
    localparam ssc_ctrl_s C_PRDW = 6'h0C;
    localparam ssc_ctrl_s C_CWR = 6'h14;
    localparam ssc_ctrl_s C_CWRH = 6'h15;
    localparam ssc_ctrl_s C_CWRL = 6'h16;
    localparam ssc_ctrl_s C_CRD = 6'h17;
    localparam ssc_ctrl_s C_NRD = 6'h3B;
    localparam ssc_ctrl_s C_NWR = 6'h18;
    localparam ssc_ctrl_s C_SWR = 6'h1C;
    localparam ssc_ctrl_s C_SRD = 6'h1F;

    logic clk = 1'b0;
    logic reset = 1'b1;
    ssc_ctrl_s ctrl;
    logic output_enable_n;
    ssc_addr_t addr;
    ssc_word_t m_word, out_word, bus;
    logic [15:0] data_io_out;
    logic data_io_oe, low_parity_io_out, low_parity_io_oe;
    logic high_parity_io_out, high_parity_io_oe, write_buf_full, power_down;
    int failures = 0;
    int checked = 0;
    int cyc_n = 0;
    ssc_word_t mem [16];
    ssc_tb_exp_s q[$];

    always #20 clk = ~clk;

    assign out_word = {high_parity_io_out, data_io_out[15:8], low_parity_io_out,
                       data_io_out[7:0]};
    assign bus = data_io_oe ? out_word : m_word;
    logic [2:0] oe_all;
    assign oe_all = {data_io_oe, low_parity_io_oe, high_parity_io_oe};

    ssc_bus_master master (.clk(clk), .ctrl(ctrl), .output_enable_n(output_enable_n),
        .addr(addr), .wdata(m_word));

    ssc_sram_ctrl #(.MEM_AW(4)) uut (.clk(clk), .reset(reset),
        .chip_sel_n(ctrl.chip_sel_n), .proc_addr_strobe_n(ctrl.proc_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl.ctrl_addr_strobe_n), .burst_advance_n(ctrl.burst_advance_n),
        .low_byte_write_n(ctrl.low_byte_write_n), .high_byte_write_n(ctrl.high_byte_write_n),
        .output_enable_n(output_enable_n), .addr_in(addr),
        .data_io_in({bus[16:9], bus[7:0]}), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .low_parity_io_in(bus[8]),
        .low_parity_io_out(low_parity_io_out), .low_parity_io_oe(low_parity_io_oe),
        .high_parity_io_in(bus[17]), .high_parity_io_out(high_parity_io_out),
        .high_parity_io_oe(high_parity_io_oe), .write_buf_full(write_buf_full),
        .power_down(power_down));

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Ceiling well above the 60-odd cycles the run needs
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n > 3000) begin
            failures++;
            wrap_up();
        end
    end

    // Outcome shows one edge after the edge that samples the cycle
    always @(negedge clk) begin
        if (q.size() > 0 && q[0].due == cyc_n) begin
            check("data_oe", {15'h0000, oe_all}, {15'h0000, {3{q[0].oe}}});
            if (q[0].oe)
                check("read_word", out_word, q[0].w);
            void'(q.pop_front());
        end
    end

    task automatic op(input ssc_ctrl_s c, input logic [3:0] a, input ssc_word_t d,
                      input logic rd, input ssc_word_t e);
        logic p;
        master.cycle(c, {12'h000, a}, d, p);
        #1;
        q.push_back('{cyc_n + 1, rd && !p, e});
    endtask

    task automatic wr(input ssc_ctrl_s c, input logic [3:0] pin_a, input logic [3:0] a,
                      input ssc_word_t d);
        op(c, pin_a, d, 1'b0, d);
        if (!c.low_byte_write_n)
            mem[a][8:0] = d[8:0];
        if (!c.high_byte_write_n)
            mem[a][17:9] = d[17:9];
    endtask

    task automatic idle(input int n);
        repeat (n) op(C_IDLE, 4'h0, 18'h0_0000, 1'b0, 18'h0_0000);
    endtask

    task automatic t_burst();
        wr(C_CWR, 4'h6, 4'h6, 18'h1_2345);
        for (int k = 1; k < 4; k++)
            wr(C_NWR, 4'h9, {2'b01, 2'b10 ^ k[1:0]}, 18'(18'h0_1111 * k));
        check("buf_full", {17'h0_0000, write_buf_full}, 18'h0_0000);
        idle(2);
        op(C_PRD, 4'h6, 18'h0_0000, 1'b1, mem[6]);
        for (int k = 1; k < 4; k++)
            op(C_NRD, 4'h9, 18'h0_0000, 1'b1, mem[{2'b01, 2'b10 ^ k[1:0]}]);
        idle(2);
    endtask

    task automatic t_lanes();
        wr(C_CWR, 4'h1, 4'h1, 18'h2_AAAA);
        wr(C_CWRL, 4'h1, 4'h1, 18'h1_5555);
        wr(C_CWRH, 4'h1, 4'h1, 18'h0_C3C3);
        idle(2);
        op(C_CRD, 4'h1, 18'h0_0000, 1'b1, mem[1]);
        idle(2);
    endtask

    task automatic t_suspend();
        wr(C_CWR, 4'h9, 4'h9, 18'h0_0F0F);
        wr(C_CWR, 4'h8, 4'h8, 18'h3_0001);
        wr(C_SWR, 4'h2, 4'h8, 18'h2_0202);
        idle(2);
        op(C_PRD, 4'h9, 18'h0_0000, 1'b1, mem[9]);
        wr(C_SWR, 4'h2, 4'h9, 18'h1_ABCD);
        idle(2);
        op(C_PRD, 4'h8, 18'h0_0000, 1'b1, mem[8]);
        op(C_SRD, 4'h2, 18'h0_0000, 1'b1, mem[8]);
        op(C_NRD, 4'h2, 18'h0_0000, 1'b1, mem[9]);
        idle(2);
    endtask

    task automatic t_deselect();
        idle(2);
        check("power_down", {17'h0_0000, power_down}, 18'h0_0001);
        op(C_NRD, 4'h6, 18'h0_0000, 1'b0, 18'h0_0000);
        op(C_PRDW, 4'h6, 18'h3_FFFF, 1'b1, mem[6]);
        op(C_NRD, 4'h6, 18'h0_0000, 1'b1, mem[7]);
        idle(1);
        master.oe_req = 1'b1;
        idle(3);
        op(C_PRD, 4'h6, 18'h0_0000, 1'b0, mem[6]);
        master.oe_req = 1'b0;
        idle(4);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        check("oe_in_reset", {data_io_oe, low_parity_io_oe, high_parity_io_oe}, 3'h0);
        check("pd_in_reset", {17'h0_0000, power_down}, 18'h0_0001);
        repeat (6) @(negedge clk);
        reset = 1'b0;
        idle(2);
        t_burst();
        t_lanes();
        t_suspend();
        t_deselect();
        wrap_up();
    end
endmodule

// ### rtl/ssc_pkg.sv
package ssc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int SSC_ADDR_W = 16;
    localparam int SSC_DATA_W = 16;
    localparam int SSC_BYTE_W = 9;
    localparam int SSC_LANES = 2;
    localparam int SSC_WORD_W = SSC_BYTE_W * SSC_LANES;
    localparam int SSC_BURST_W = 2;
    localparam int SSC_BUF_DEPTH = 2;
    localparam int SSC_LANE_DATA_LSB = 0;
    localparam int SSC_LANE_PARITY_BIT = 8;

    // ------------------------------------------------------------
    // Reset values and burst steps
    // ------------------------------------------------------------
    localparam logic [1:0] SSC_BURST_START = 2'h0;
    localparam logic [1:0] SSC_BURST_STEP = 2'h1;
    localparam logic [15:0] SSC_ADDR_RESET = 16'h0000;
    localparam logic [15:0] SSC_DATA_RESET = 16'h0000;
    localparam logic [17:0] SSC_WORD_RESET = 18'h0_0000;
    localparam logic [5:0] SSC_CTRL_IDLE = 6'h3F;

    typedef logic [SSC_ADDR_W-1:0] ssc_addr_t;
    typedef logic [SSC_WORD_W-1:0] ssc_word_t;

    // Synchronous control pins, active low; output enable is sampled apart
    typedef struct packed {
        logic chip_sel_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic high_byte_write_n;
        logic low_byte_write_n;
    } ssc_ctrl_s;

    // One pending array write
    typedef struct packed {
        ssc_addr_t addr;
        ssc_word_t data;
        logic [SSC_LANES-1:0] lane_en;
    } ssc_wreq_s;

    typedef enum logic [2:0] {
        SSC_CYC_IDLE,
        SSC_CYC_DESEL,
        SSC_CYC_RD_BEGIN,
        SSC_CYC_WR_BEGIN,
        SSC_CYC_RD_NEXT,
        SSC_CYC_WR_NEXT,
        SSC_CYC_RD_HOLD,
        SSC_CYC_WR_HOLD
    } ssc_cyc_e;

endpackage

// ### rtl/ssc_sram_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - Chip unselected plus strobe: power down, Hi-Z
// - Processor strobe while selected always starts read
// - Controller strobe starts read or write burst
// - No strobes, advance: next address, read
// - No strobes, advance, write low: write next
// - No strobes, no advance: hold address, wait
// - Suspended write goes to current address
// - Read data driven only while output enable low
// - Byte enables gate their own lane and parity
// - Sync inputs sampled on rising clock edge
// - Data pins undriven from power-up until the first read
// - Wait cycle after processor read may write
// - Interleaved two-bit burst counter on low bits
module ssc_sram_ctrl
    import ssc_pkg::*;
#(
    parameter int MEM_AW = SSC_ADDR_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_sel_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic output_enable_n,
    input wire logic [SSC_ADDR_W-1:0] addr_in,
    input wire logic [SSC_DATA_W-1:0] data_io_in,
    output logic [SSC_DATA_W-1:0] data_io_out,
    output logic data_io_oe,
    input wire logic low_parity_io_in,
    output logic low_parity_io_out,
    output logic low_parity_io_oe,
    input wire logic high_parity_io_in,
    output logic high_parity_io_out,
    output logic high_parity_io_oe,
    output logic write_buf_full,
    output logic power_down
);

    localparam int WB = $bits(ssc_wreq_s);

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    ssc_ctrl_s ctrl_reg, ctrl_next;
    ssc_addr_t addr_reg, addr_next;
    ssc_word_t wdata_reg, wdata_next;
    logic oe_meta_reg, oe_meta_next;
    logic oe_sync_reg, oe_sync_next;

    // Bus pins share clk with the master, so one stage suffices
    always_comb begin
        ctrl_next.chip_sel_n = chip_sel_n;
        ctrl_next.proc_addr_strobe_n = proc_addr_strobe_n;
        ctrl_next.ctrl_addr_strobe_n = ctrl_addr_strobe_n;
        ctrl_next.burst_advance_n = burst_advance_n;
        ctrl_next.high_byte_write_n = high_byte_write_n;
        ctrl_next.low_byte_write_n = low_byte_write_n;
        addr_next = addr_in;
        wdata_next = {high_parity_io_in, data_io_in[15:8],
                      low_parity_io_in, data_io_in[7:0]};
        // Output enable is asynchronous: two stages before any use
        oe_meta_next = output_enable_n;
        oe_sync_next = oe_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= SSC_CTRL_IDLE;
            addr_reg <= SSC_ADDR_RESET;
            wdata_reg <= SSC_WORD_RESET;
            oe_meta_reg <= 1'b1;
            oe_sync_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            oe_meta_reg <= oe_meta_next;
            oe_sync_reg <= oe_sync_next;
        end
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    ssc_cyc_e cyc;
    logic write_low;
    logic [SSC_LANES-1:0] lane_en;
    logic selected_reg, selected_next;

    always_comb begin
        // Either byte enable low makes a controller-strobe or burst-continue cycle a write
        lane_en = {~ctrl_reg.high_byte_write_n, ~ctrl_reg.low_byte_write_n};
        write_low = |lane_en;
        if (ctrl_reg.chip_sel_n && (!ctrl_reg.proc_addr_strobe_n ||
                                    !ctrl_reg.ctrl_addr_strobe_n)) begin
            cyc = SSC_CYC_DESEL;
        end else if (!ctrl_reg.proc_addr_strobe_n) begin
            cyc = SSC_CYC_RD_BEGIN;
        end else if (!ctrl_reg.ctrl_addr_strobe_n) begin
            cyc = write_low ? SSC_CYC_WR_BEGIN : SSC_CYC_RD_BEGIN;
        end else if (!selected_reg) begin
            // Powered down: a continue cycle has no burst to follow
            cyc = SSC_CYC_IDLE;
        end else if (!ctrl_reg.burst_advance_n) begin
            cyc = write_low ? SSC_CYC_WR_NEXT : SSC_CYC_RD_NEXT;
        end else begin
            cyc = write_low ? SSC_CYC_WR_HOLD : SSC_CYC_RD_HOLD;
        end
    end

    // ------------------------------------------------------------
    // Burst address
    // ------------------------------------------------------------
    ssc_addr_t base_reg, base_next;
    logic [SSC_BURST_W-1:0] cnt_reg, cnt_next;
    ssc_addr_t acc_addr;
    logic rd_access, wr_access;

    always_comb begin
        base_next = base_reg;
        cnt_next = cnt_reg;
        selected_next = selected_reg;
        rd_access = 1'b0;
        wr_access = 1'b0;
        case (cyc)
            SSC_CYC_DESEL: begin
                // Address pins ignored: base and counter keep their values
                selected_next = 1'b0;
            end
            SSC_CYC_RD_BEGIN, SSC_CYC_WR_BEGIN: begin
                base_next = addr_reg;
                cnt_next = SSC_BURST_START;
                selected_next = 1'b1;
                rd_access = (cyc == SSC_CYC_RD_BEGIN);
                wr_access = (cyc == SSC_CYC_WR_BEGIN);
            end
            SSC_CYC_RD_NEXT, SSC_CYC_WR_NEXT: begin
                cnt_next = cnt_reg + SSC_BURST_STEP;
                rd_access = (cyc == SSC_CYC_RD_NEXT);
                wr_access = (cyc == SSC_CYC_WR_NEXT);
            end
            SSC_CYC_RD_HOLD, SSC_CYC_WR_HOLD: begin
                rd_access = (cyc == SSC_CYC_RD_HOLD);
                wr_access = (cyc == SSC_CYC_WR_HOLD);
            end
            default: begin
                rd_access = 1'b0;
            end
        endcase
        // Counter only flips the low bits, so the order is interleaved
        acc_addr = {base_next[SSC_ADDR_W-1:SSC_BURST_W],
                    base_next[SSC_BURST_W-1:0] ^ cnt_next};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            base_reg <= SSC_ADDR_RESET;
            cnt_reg <= SSC_BURST_START;
            selected_reg <= 1'b0;
        end else begin
            base_reg <= base_next;
            cnt_reg <= cnt_next;
            selected_reg <= selected_next;
        end
    end

    // ------------------------------------------------------------
    // Write buffer and array
    // ------------------------------------------------------------
    ssc_wreq_s wreq, drain_req;
    logic buf_in_ready, drain_valid, drain_ready;
    logic [SSC_BUF_DEPTH*WB-1:0] buf_slots;
    logic [SSC_BUF_DEPTH-1:0] buf_slot_valid;
    logic [((SSC_BUF_DEPTH > 1) ? $clog2(SSC_BUF_DEPTH) : 1)-1:0] buf_head;
    logic [WB-1:0] drain_bits;
    ssc_word_t mem [2**MEM_AW];
    ssc_word_t mem_old, mem_wdata, rd_word;

    always_comb begin
        wreq.addr = acc_addr;
        wreq.data = wdata_reg;
        wreq.lane_en = lane_en;
        drain_req = drain_bits;
        // A write pops the head as it pushes, so at most one word waits
        // Single array port: a read takes it, the write waits in the buffer
        drain_ready = !rd_access;
    end

    ssc_word_buf #(
        .W(WB),
        .DEPTH(SSC_BUF_DEPTH)
    ) u_wbuf (
        .clk(clk),
        .reset(reset),
        .in_valid(wr_access),
        .in_ready(buf_in_ready),
        .in_data(wreq),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_bits),
        .slot_data(buf_slots),
        .slot_valid(buf_slot_valid),
        .head_idx(buf_head)
    );

    assign mem_old = mem[drain_req.addr[MEM_AW-1:0]];

    for (genvar g = 0; g < SSC_LANES; g++) begin : g_lane
        assign mem_wdata[g*SSC_BYTE_W +: SSC_BYTE_W] = drain_req.lane_en[g] ?
            drain_req.data[g*SSC_BYTE_W +: SSC_BYTE_W] :
            mem_old[g*SSC_BYTE_W +: SSC_BYTE_W];
    end

    always_ff @(posedge clk) begin
        if (drain_valid && drain_ready) begin
            mem[drain_req.addr[MEM_AW-1:0]] <= mem_wdata;
        end
    end

    // Reads see still-buffered writes, oldest first
    // Newer entries overwrite older ones lane by lane
    always_comb begin
        ssc_wreq_s ent;
        int idx;
        ent = '0;
        idx = 0;
        rd_word = mem[acc_addr[MEM_AW-1:0]];
        for (int i = 0; i < SSC_BUF_DEPTH; i++) begin
            idx = (int'(buf_head) + i) % SSC_BUF_DEPTH;
            ent = buf_slots[idx*WB +: WB];
            if (buf_slot_valid[idx] && (ent.addr[MEM_AW-1:0] == acc_addr[MEM_AW-1:0])) begin
                for (int l = 0; l < SSC_LANES; l++) begin
                    if (ent.lane_en[l]) begin
                        rd_word[l*SSC_BYTE_W +: SSC_BYTE_W] =
                            ent.data[l*SSC_BYTE_W +: SSC_BYTE_W];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic [SSC_DATA_W-1:0] dout_reg, dout_next;
    logic lpar_reg, lpar_next, hpar_reg, hpar_next;
    logic drive_reg, drive_next;
    logic full_reg, full_next;
    logic pdown_reg, pdown_next;

    always_comb begin
        // Data register keeps the last read word; only the enable moves
        dout_next = dout_reg;
        lpar_next = lpar_reg;
        hpar_next = hpar_reg;
        if (rd_access) begin
            dout_next = {rd_word[2*SSC_BYTE_W-2:SSC_BYTE_W],
                         rd_word[SSC_LANE_PARITY_BIT-1:SSC_LANE_DATA_LSB]};
            lpar_next = rd_word[SSC_LANE_PARITY_BIT];
            hpar_next = rd_word[SSC_BYTE_W + SSC_LANE_PARITY_BIT];
        end
        // Limitation: the enable pin reaches the drivers three edges late
        // Writes, deselects and idle cycles release the bus
        drive_next = rd_access && !oe_sync_reg;
        full_next = !buf_in_ready;
        pdown_next = !selected_next;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dout_reg <= SSC_DATA_RESET;
            lpar_reg <= 1'b0;
            hpar_reg <= 1'b0;
            drive_reg <= 1'b0;
            full_reg <= 1'b0;
            pdown_reg <= 1'b1;
        end else begin
            dout_reg <= dout_next;
            lpar_reg <= lpar_next;
            hpar_reg <= hpar_next;
            drive_reg <= drive_next;
            full_reg <= full_next;
            pdown_reg <= pdown_next;
        end
    end

    assign data_io_out = dout_reg;
    assign low_parity_io_out = lpar_reg;
    assign high_parity_io_out = hpar_reg;
    assign data_io_oe = drive_reg;
    assign low_parity_io_oe = drive_reg;
    assign high_parity_io_oe = drive_reg;
    assign write_buf_full = full_reg;
    assign power_down = pdown_reg;

endmodule

// ### rtl/ssc_word_buf.sv
`timescale 1ns/1ps

module ssc_word_buf
    import ssc_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = SSC_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [DEPTH*W-1:0] slot_data,
    output logic [DEPTH-1:0] slot_valid,
    output logic [((DEPTH > 1) ? $clog2(DEPTH) : 1)-1:0] head_idx
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [W-1:0] slot_reg [DEPTH];
    logic [W-1:0] slot_next [DEPTH];
    logic [PW-1:0] head_reg, head_next, tail_reg, tail_next;
    logic [PW:0] count_reg, count_next;
    logic push, pop;

    // ------------------------------------------------------------
    // Pointers and storage
    // ------------------------------------------------------------
    // No pass-through on full: keeps in_ready free of out_ready paths
    assign in_ready = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != '0);
    assign out_data = slot_reg[head_reg];
    assign head_idx = head_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        slot_next = slot_reg;
        head_next = head_reg;
        tail_next = tail_reg;
        count_next = count_reg;
        if (push) begin
            slot_next[tail_reg] = in_data;
            tail_next = (tail_reg == LAST_PTR) ? '0 : tail_reg + PW'(1);
            count_next = count_next + (PW + 1)'(1);
        end
        if (pop) begin
            head_next = (head_reg == LAST_PTR) ? '0 : head_reg + PW'(1);
            count_next = count_next - (PW + 1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            head_reg <= '0;
            tail_reg <= '0;
            count_reg <= '0;
        end else begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            count_reg <= count_next;
        end
        slot_reg <= slot_next;
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_slot
        assign slot_data[g*W +: W] = slot_reg[g];
        assign slot_valid[g] =
            (PW + 1)'((g + DEPTH - int'(head_reg)) % DEPTH) < count_reg;
    end

endmodule
